/* File: logic/ifcr_pkg.sv */
package ifcr_pkg;

  // Register offsets on the special function register bus
  localparam logic [7:0] IFCR_TRIGGER_ADDR   = 8'ha4;
  localparam logic [7:0] IFCR_ADDR_LOW_ADDR  = 8'ha6;
  localparam logic [7:0] IFCR_ADDR_HIGH_ADDR = 8'ha7;
  localparam logic [7:0] IFCR_DATA_ADDR      = 8'hae;
  localparam logic [7:0] IFCR_COMMAND_ADDR   = 8'haf;

  // Reset values
  localparam logic [7:0] IFCR_ADDR_LOW_RST   = 8'h00;
  localparam logic [7:0] IFCR_ADDR_HIGH_RST  = 8'h00;
  localparam logic [7:0] IFCR_DATA_RST       = 8'h00;
  localparam logic [7:0] IFCR_COMMAND_RST    = 8'h30;

  // Field positions
  localparam int IFCR_START_BIT    = 0;
  localparam int IFCR_EXT_MSB      = 7;
  localparam int IFCR_EXT_LSB      = 6;
  localparam int IFCR_OE_BIT       = 5;
  localparam int IFCR_CE_BIT       = 4;
  localparam int IFCR_FUNC_MSB     = 3;
  localparam int IFCR_FUNC_LSB     = 0;

  // Function codes
  localparam logic [3:0] IFCR_FUNC_READ    = 4'h0;
  localparam logic [3:0] IFCR_FUNC_PROGRAM = 4'h1;
  localparam logic [3:0] IFCR_FUNC_ERASE   = 4'h2;

  // Destination codes carried in the address extension bits
  localparam logic [1:0] IFCR_DEST_MAIN    = 2'h0;
  localparam logic [1:0] IFCR_DEST_LOADER  = 2'h1;
  localparam logic [1:0] IFCR_DEST_CONFIG  = 2'h3;

  // Erase page geometry: 128 bytes, so the low 7 address bits are dropped
  localparam int          IFCR_PAGE_BYTES = 128;
  localparam logic [17:0] IFCR_PAGE_MASK  = ~18'(IFCR_PAGE_BYTES - 1);

  // Default size of the main array, in bytes
  localparam logic [17:0] IFCR_MAIN_SIZE_DEF = 18'h10000;

  typedef enum logic [3:0] {
    IFCR_IDLE   = 4'b0001,
    IFCR_LAUNCH = 4'b0010,
    IFCR_WAIT   = 4'b0100,
    IFCR_FINISH = 4'b1000
  } ifcr_state_type;

endpackage

/* File: logic/ifcr_byte_if.sv */
`timescale 1ns/10ps
interface ifcr_byte_if;
  logic       sw_wr;
  logic [7:0] sw_data;
  logic       hw_wr;
  logic [7:0] hw_data;
  logic [7:0] value;

  modport ctrl  (output sw_wr, output sw_data, output hw_wr, output hw_data, input value);
  modport store (input sw_wr, input sw_data, input hw_wr, input hw_data, output value);
endinterface

/* File: logic/ifcr_byte_reg.sv */
`timescale 1ns/10ps
module ifcr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input  wire logic  core_clk_in,
  input  wire logic  reset_in,
  // Access port
  ifcr_byte_if.store port
);

  // Hardware load wins so a completing read is never lost
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      port.value <= RESET_VALUE;
    end else if (port.hw_wr) begin
      port.value <= port.hw_data;
    end else if (port.sw_wr) begin
      port.value <= port.sw_data;
    end
  end

endmodule

/* File: logic/ifcr_top.sv */
`timescale 1ns/10ps
module ifcr_top
  import ifcr_pkg::*;
#(
  parameter logic [17:0] MAIN_SIZE = ifcr_pkg::IFCR_MAIN_SIZE_DEF
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Special function register bus
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  // Chip control and timed access
  input  wire logic        programming_enable_in,
  input  wire logic        timed_access_unlock_in,
  input  wire logic        boot_from_loader_in,
  input  wire logic        fault_clear_in,
  output logic             fault_flag_out,
  // CPU stall
  output logic             pc_hold_out,
  // Flash macro port
  output logic      [17:0] flash_addr_out,
  output logic      [7:0]  flash_wdata_out,
  output logic             flash_read_out,
  output logic             flash_program_out,
  output logic             flash_erase_out,
  input  wire logic        flash_done_in,
  input  wire logic [7:0]  flash_rdata_in
);
  import ifcr_pkg::*;

  ifcr_byte_if addr_low_bus ();
  ifcr_byte_if addr_high_bus ();
  ifcr_byte_if data_bus ();
  ifcr_byte_if command_bus ();

  ifcr_state_type state_reg;
  ifcr_state_type state_next;

  logic        trigger_hit;
  logic        start_req;
  logic        op_legal;
  logic        op_read;
  logic        op_program;
  logic        op_erase;
  logic [17:0] target_address;
  logic [1:0]  dest;
  logic [3:0]  function_code;
  logic        output_enable_field;
  logic        read_pending_reg;

  ifcr_byte_reg #(.RESET_VALUE(IFCR_ADDR_LOW_RST)) addr_low_reg (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .port        (addr_low_bus.store)
  );

  ifcr_byte_reg #(.RESET_VALUE(IFCR_ADDR_HIGH_RST)) addr_high_reg (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .port        (addr_high_bus.store)
  );

  ifcr_byte_reg #(.RESET_VALUE(IFCR_DATA_RST)) data_reg (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .port        (data_bus.store)
  );

  ifcr_byte_reg #(.RESET_VALUE(IFCR_COMMAND_RST)) command_reg (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .port        (command_bus.store)
  );

  // Software writes; the CPU is stalled while busy, so these never race
  assign addr_low_bus.sw_wr    = sfr_wr_in && (sfr_addr_in == IFCR_ADDR_LOW_ADDR);
  assign addr_low_bus.sw_data  = sfr_wdata_in;
  assign addr_low_bus.hw_wr    = 1'b0;
  assign addr_low_bus.hw_data  = 8'h00;
  assign addr_high_bus.sw_wr   = sfr_wr_in && (sfr_addr_in == IFCR_ADDR_HIGH_ADDR);
  assign addr_high_bus.sw_data = sfr_wdata_in;
  assign addr_high_bus.hw_wr   = 1'b0;
  assign addr_high_bus.hw_data = 8'h00;
  assign command_bus.sw_wr     = sfr_wr_in && (sfr_addr_in == IFCR_COMMAND_ADDR);
  assign command_bus.sw_data   = sfr_wdata_in;
  assign command_bus.hw_wr     = 1'b0;
  assign command_bus.hw_data   = 8'h00;
  assign data_bus.sw_wr        = sfr_wr_in && (sfr_addr_in == IFCR_DATA_ADDR);
  assign data_bus.sw_data      = sfr_wdata_in;

  // Read result captured at completion
  assign data_bus.hw_wr   = (state_reg == IFCR_WAIT) && flash_done_in && read_pending_reg;
  assign data_bus.hw_data = flash_rdata_in;

  // Command decode
  assign dest                = command_bus.value[IFCR_EXT_MSB:IFCR_EXT_LSB];
  assign output_enable_field = command_bus.value[IFCR_OE_BIT];
  assign function_code       = command_bus.value[IFCR_FUNC_MSB:IFCR_FUNC_LSB];
  assign target_address      = {dest, addr_high_bus.value, addr_low_bus.value};

  assign op_read    = (function_code == IFCR_FUNC_READ) && !output_enable_field;
  assign op_program = (function_code == IFCR_FUNC_PROGRAM) && output_enable_field;
  assign op_erase   = (function_code == IFCR_FUNC_ERASE) && output_enable_field;

  // Config space is reachable only from loader code; main array has a size limit
  always_comb begin
    case (dest)
      IFCR_DEST_MAIN:   op_legal = target_address < MAIN_SIZE;
      IFCR_DEST_LOADER: op_legal = 1'b1;
      IFCR_DEST_CONFIG: op_legal = boot_from_loader_in;
      default:          op_legal = 1'b0;
    endcase
  end

  // Trigger write accepted only unlocked, enabled and idle
  assign trigger_hit = sfr_wr_in && (sfr_addr_in == IFCR_TRIGGER_ADDR);
  assign start_req   = trigger_hit && sfr_wdata_in[IFCR_START_BIT]
                     && timed_access_unlock_in
                     && programming_enable_in
                     && (state_reg == IFCR_IDLE);

  always_comb begin
    case (state_reg)
      IFCR_IDLE: begin
        state_next = start_req ? IFCR_LAUNCH : IFCR_IDLE;
      end
      IFCR_LAUNCH: begin
        state_next = (op_legal && (op_read || op_program || op_erase)) ? IFCR_WAIT : IFCR_FINISH;
      end
      IFCR_WAIT: begin
        state_next = flash_done_in ? IFCR_FINISH : IFCR_WAIT;
      end
      IFCR_FINISH: begin
        state_next = IFCR_IDLE;
      end
      default: begin
        state_next = IFCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= IFCR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stall spans launch through finish; drops as the machine returns to idle
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_hold_out <= 1'b0;
    end else begin
      pc_hold_out <= (state_next != IFCR_IDLE);
    end
  end

  // Flash strobes are single-cycle pulses at launch
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_addr_out    <= 18'h00000;
      flash_wdata_out   <= 8'h00;
      flash_read_out    <= 1'b0;
      flash_program_out <= 1'b0;
      flash_erase_out   <= 1'b0;
      read_pending_reg  <= 1'b0;
    end else if ((state_reg == IFCR_LAUNCH) && op_legal) begin
      flash_addr_out    <= op_erase ? (target_address & IFCR_PAGE_MASK) : target_address;
      flash_wdata_out   <= data_bus.value;
      flash_read_out    <= op_read;
      flash_program_out <= op_program;
      flash_erase_out   <= op_erase;
      read_pending_reg  <= op_read;
    end else begin
      flash_read_out    <= 1'b0;
      flash_program_out <= 1'b0;
      flash_erase_out   <= 1'b0;
      if (state_reg == IFCR_FINISH) begin
        read_pending_reg <= 1'b0;
      end
    end
  end

  // Fault: hardware set wins over software clear
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fault_flag_out <= 1'b0;
    end else if ((state_reg == IFCR_LAUNCH) && !(op_legal && (op_read || op_program || op_erase))) begin
      fault_flag_out <= 1'b1;
    end else if (fault_clear_in) begin
      fault_flag_out <= 1'b0;
    end
  end

  // Registered read data; trigger and unmapped addresses read zero
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        IFCR_ADDR_LOW_ADDR:  sfr_rdata_out <= addr_low_bus.value;
        IFCR_ADDR_HIGH_ADDR: sfr_rdata_out <= addr_high_bus.value;
        IFCR_DATA_ADDR:      sfr_rdata_out <= data_bus.value;
        IFCR_COMMAND_ADDR:   sfr_rdata_out <= command_bus.value;
        IFCR_TRIGGER_ADDR:   sfr_rdata_out <= 8'h00;
        default:             sfr_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule

/* File: bench/ifcr_top_sva.sv */
`timescale 1ns/10ps
module ifcr_checker
  import ifcr_pkg::*;
(
  // Clock, reset and register bus
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  sfr_addr_in,
  input wire logic        sfr_wr_in,
  input wire logic        sfr_rd_in,
  input wire logic [7:0]  sfr_wdata_in,
  input wire logic [7:0]  sfr_rdata_out,
  // Control and status
  input wire logic        programming_enable_in,
  input wire logic        timed_access_unlock_in,
  input wire logic        fault_clear_in,
  input wire logic        fault_flag_out,
  input wire logic        pc_hold_out,
  // Flash side
  input wire logic [17:0] flash_addr_out,
  input wire logic        flash_read_out,
  input wire logic        flash_program_out,
  input wire logic        flash_erase_out,
  input wire logic        flash_done_in
);
  logic [15:0] addr_reg;
  logic        wait_reg;
  wire st = flash_read_out | flash_program_out | flash_erase_out;
  wire tw = sfr_wr_in && sfr_addr_in == IFCR_TRIGGER_ADDR && sfr_wdata_in[0] && !pc_hold_out;
  // Shadow of the address bytes, written on any bus write to them, even while the CPU is held
  always_ff @(posedge core_clk_in or posedge reset_in)
    if (reset_in) addr_reg <= 16'h0000;
    else if (sfr_wr_in && sfr_addr_in == IFCR_ADDR_HIGH_ADDR) addr_reg[15:8] <= sfr_wdata_in;
    else if (sfr_wr_in && sfr_addr_in == IFCR_ADDR_LOW_ADDR) addr_reg[7:0] <= sfr_wdata_in;
  always_ff @(posedge core_clk_in or posedge reset_in)
    if (reset_in) wait_reg <= 1'b0;
    else wait_reg <= (wait_reg | st) & !flash_done_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  property p_start; tw && timed_access_unlock_in && programming_enable_in |=> pc_hold_out ##1 (st || fault_flag_out); endproperty
  a_start: assert property (p_start) else $error("no launch after trigger");
  property p_locked; tw && !timed_access_unlock_in |=> !pc_hold_out; endproperty
  a_locked: assert property (p_locked) else $error("locked trigger taken");
  property p_enable; tw && !programming_enable_in |=> !pc_hold_out; endproperty
  a_enable: assert property (p_enable) else $error("trigger taken while disabled");
  property p_hold; st || wait_reg |-> pc_hold_out; endproperty
  a_hold: assert property (p_hold) else $error("cpu not held during operation");
  property p_release; flash_done_in && (st || wait_reg) |=> pc_hold_out ##[1:2] !pc_hold_out; endproperty
  a_release: assert property (p_release) else $error("hold not released");
  property p_addr; flash_read_out || flash_program_out |-> flash_addr_out[15:0] == addr_reg; endproperty
  a_addr: assert property (p_addr) else $error("wrong target address");
  property p_erase; flash_erase_out |-> flash_addr_out[15:0] == (addr_reg & 16'hff80); endproperty
  a_erase: assert property (p_erase) else $error("erase page not aligned");
  property p_trig_zero; sfr_rd_in && sfr_addr_in == IFCR_TRIGGER_ADDR |=> sfr_rdata_out == 8'h00; endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger read not zero");
  property p_fault; fault_flag_out && !fault_clear_in |=> fault_flag_out; endproperty
  a_fault: assert property (p_fault) else $error("fault flag lost");
endmodule
bind ifcr_top ifcr_checker ifcr_checker_i (.*);

/* File: bench/ifcr_flash_model.sv */
`timescale 1ns/10ps
module ifcr_flash_model (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // Strobes from the block
  input  wire logic [17:0] flash_addr_in,
  input  wire logic [7:0]  flash_wdata_in,
  input  wire logic        flash_read_in,
  input  wire logic        flash_program_in,
  input  wire logic        flash_erase_in,
  input  wire logic [3:0]  delay_in,
  // Completion
  output logic             flash_done_out,
  output logic      [7:0]  flash_rdata_out
);
  logic [7:0] mem [256];
  logic [7:0] rd_reg;
  logic [4:0] cnt_reg;
  // Data is only valid with done; otherwise show the inverse
  assign flash_rdata_out = flash_done_out ? rd_reg : ~rd_reg;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    flash_done_out <= 1'b0;
    if (reset_in) begin
      cnt_reg <= 5'h00;
    end else if (flash_read_in | flash_program_in | flash_erase_in) begin
      cnt_reg <= {1'b0, delay_in} + 5'h01;
      rd_reg <= mem[flash_addr_in[7:0]];
      if (flash_program_in)
        mem[flash_addr_in[7:0]] <= flash_wdata_in;
      if (flash_erase_in)
        for (int i = 0; i < 128; i++)
          mem[{flash_addr_in[7], i[6:0]}] <= 8'hff;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      flash_done_out <= (cnt_reg == 5'h01);
    end
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import ifcr_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        en = 1'b1;
  logic        unlock = 1'b0;
  logic        fclr = 1'b0;
  logic        boot = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  rdata, frdata, fwdata, st_data;
  logic [17:0] faddr, st_addr;
  logic        fault, hold, fr, fp, fe, fdone;
  logic [2:0]  st_kind;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #4 core_clk_in = ~core_clk_in;
  ifcr_top ifcr_top_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .programming_enable_in(en), .timed_access_unlock_in(unlock), .boot_from_loader_in(boot),
    .fault_clear_in(fclr), .fault_flag_out(fault), .pc_hold_out(hold),
    .flash_addr_out(faddr), .flash_wdata_out(fwdata), .flash_read_out(fr),
    .flash_program_out(fp), .flash_erase_out(fe), .flash_done_in(fdone),
    .flash_rdata_in(frdata));
  ifcr_flash_model ifcr_flash_model_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .flash_addr_in(faddr), .flash_wdata_in(fwdata), .flash_read_in(fr),
    .flash_program_in(fp), .flash_erase_in(fe), .delay_in(dly),
    .flash_done_out(fdone), .flash_rdata_out(frdata));
  always @(posedge core_clk_in)
    if (fr | fp | fe) begin
      st_addr <= faddr;
      st_data <= fwdata;
      st_kind <= {fr, fp, fe};
    end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Command, then a trigger write with the unlock level u
  task automatic go(input logic [7:0] cmd, input logic u, input logic ok);
    int n;
    sfr_wr(IFCR_COMMAND_ADDR, cmd);
    unlock <= u;
    sfr_wr(IFCR_TRIGGER_ADDR, 8'h01);
    unlock <= 1'b0;
    #1 chk(hold, ok);
    for (n = 0; n < 300 && hold === 1'b1; n++)
      @(posedge core_clk_in);
    chk(n < 300, 1'b1);
  endtask
  task automatic t_reset();
    sfr_rd(IFCR_COMMAND_ADDR, 8'h30);
    sfr_rd(IFCR_ADDR_HIGH_ADDR, 8'h00);
    sfr_rd(IFCR_DATA_ADDR, 8'h00);
    sfr_rd(IFCR_TRIGGER_ADDR, 8'h00);
    sfr_rd(8'h55, 8'h00);
  endtask
  task automatic t_program(input logic [7:0] hi, input logic [7:0] d, input logic [3:0] w);
    dly <= w;
    sfr_wr(IFCR_ADDR_HIGH_ADDR, hi);
    sfr_wr(IFCR_ADDR_LOW_ADDR, 8'hb4);
    sfr_wr(IFCR_DATA_ADDR, d);
    go(8'h21, 1'b1, 1'b1);
    chk(st_kind, 3'b010);
    chk(st_addr, {2'b00, hi, 8'hb4});
    chk(st_data, d);
    sfr_rd(IFCR_ADDR_HIGH_ADDR, hi);
    sfr_rd(IFCR_TRIGGER_ADDR, 8'h00);
    go(8'h00, 1'b1, 1'b1);
    chk(st_kind, 3'b100);
    sfr_rd(IFCR_DATA_ADDR, d);
  endtask
  task automatic t_erase();
    go(8'h22, 1'b1, 1'b1);
    chk(st_kind, 3'b001);
    chk(st_addr, 18'h07780);
    go(8'h00, 1'b1, 1'b1);
    sfr_rd(IFCR_DATA_ADDR, 8'hff);
  endtask
  task automatic t_lock();
    go(8'h00, 1'b0, 1'b0);
    en <= 1'b0;
    go(8'h00, 1'b1, 1'b0);
    en <= 1'b1;
  endtask
  task automatic t_fault();
    logic [7:0] bad [5] = '{8'h05, 8'h01, 8'h20, 8'ha1, 8'hc0};
    foreach (bad[i]) begin
      go(bad[i], 1'b1, 1'b1);
      chk(fault, 1'b1);
      @(posedge core_clk_in);
      fclr <= 1'b1;
      @(posedge core_clk_in);
      fclr <= 1'b0;
      #1 chk(fault, 1'b0);
    end
    sfr_rd(IFCR_COMMAND_ADDR, 8'hc0);
    // Config space opens only to loader code
    boot <= 1'b1;
    go(8'hc0, 1'b1, 1'b1);
    chk(st_kind, 3'b100);
    chk(st_addr, {2'b11, 16'h77b4});
    chk(fault, 1'b0);
    boot <= 1'b0;
  endtask
  task automatic summarize();
    $display("Mismatches %0d in %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_program(8'h77, 8'h5a, 4'h0);
    t_program(8'h77, 8'hc3, 4'h9);
    t_erase();
    t_lock();
    t_fault();
    summarize();
  end
  // Whole run is a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
